/* File: phy_housekeeping_control_defines.vh */
// register map, field positions, reset values and timing for housekeeping
`ifndef PHY_HOUSEKEEPING_CONTROL_DEFINES_VH
`define PHY_HOUSEKEEPING_CONTROL_DEFINES_VH

// register byte offsets
`define REG_CONTROL        4'h0
`define REG_STATUS         4'h4
`define REG_SLEEP_CFG      4'h8
`define REG_IRQ            4'hC

// control register fields
`define CTRL_SOFT_RESET    15
`define CTRL_AUTONEG       12
`define CTRL_POWER_DOWN    11
`define CTRL_ISOLATE       10
`define CTRL_FULL_DUPLEX   8
`define CTRL_REPEATER      1

// status register fields (read only)
`define STAT_ENERGY        0
`define STAT_LINK          1
`define STAT_SPEED100      2
`define STAT_CARRIER       3
`define STAT_ASLEEP        4
`define STAT_IRQ_MODE      5
`define STAT_MAC_FAST      6
`define STAT_LED_ACT_LOW   7

// sleep configuration fields (kept across soft reset)
`define SLP_ENABLE         0
`define SLP_TX_NLP_EN      1
`define SLP_TX_SEL_LO      2
`define SLP_SINGLE_WAKE    4
`define SLP_RX_SEL_LO      5

// interrupt register fields
`define IRQ_ENERGY_STAT    0
`define IRQ_ENERGY_MASK    8

// reset values
`define CTRL_AUTONEG_RST   1'b1
`define SLP_RX_SEL_RST     2'h0
`define SLP_TX_SEL_RST     2'h0

// timing
`define CLK_PERIOD_NS      20
`define MAC_SLOW_NS        16000
`define BLINK_HALF_NS      50000000
`define ENERGY_OFF_NS      256000000
`define NLP_TX_BASE_NS     256000000
`define NLP_RX_BASE_NS     16000000

// 4B/5B code groups, first received bit on the left
`define CODE_J             5'h18
`define CODE_K             5'h11
`define CODE_T             5'h0D
`define CODE_R             5'h07
`define CODE_IDLE          5'h1F

`endif

/* File: phy_housekeeping_control.v */
// transceiver housekeeping: straps, leds, power-down, resets, carrier sense
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`include "phy_housekeeping_control_defines.vh"

module phy_housekeeping_control #(
    parameter BLINK_HALF = `BLINK_HALF_NS / `CLK_PERIOD_NS,
    parameter ENERGY_OFF = `ENERGY_OFF_NS / `CLK_PERIOD_NS,
    parameter NLP_TX_BASE = `NLP_TX_BASE_NS / `CLK_PERIOD_NS,
    parameter NLP_RX_BASE = `NLP_RX_BASE_NS / `CLK_PERIOD_NS
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        hw_reset_n,
    input  wire        irq_pin_function_strap,
    input  wire        linkLedStrap,
    input  wire        rmiiSel,
    input  wire        linkValid,
    input  wire        speed100,
    input  wire        lineEnergy,
    input  wire        nlpReceived,
    input  wire        rxBitClk,
    input  wire        rxCodeBit,
    input  wire        macTxEn,
    input  wire        macTxEr,
    input  wire [3:0]  macTxData,
    input  wire        sharedTxPin,
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    output reg         link_activity_led,
    output reg         speed_led,
    output reg         interrupt_out_n,
    output reg         interruptOe,
    output reg         crs,
    output reg         crsDv,
    output reg         txEnOut,
    output reg         txErOut,
    output reg  [3:0]  txDataOut,
    output reg         txNlp,
    output reg         macClkFast,
    output reg         poweredDown
);

    localparam MAC_SLOW =
        (`MAC_SLOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam NSYNC = 17;

    localparam [1:0] CS_IDLE  = 2'h0;
    localparam [1:0] CS_HUNT  = 2'h1;
    localparam [1:0] CS_FRAME = 2'h2;
    localparam [1:0] CS_END   = 2'h3;

    // true when the newest five bits hold the given code group
    function codeIs;
        input [9:0] hist;
        input [4:0] code;
        begin
            codeIs = (hist[4:0] == code);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    wire [NSYNC-1:0] rawIn = {sharedTxPin, macTxData, macTxEr, macTxEn,
        rxCodeBit, rxBitClk, nlpReceived, lineEnergy, speed100, linkValid,
        rmiiSel, linkLedStrap, irq_pin_function_strap, hw_reset_n};
    reg  [NSYNC-1:0] syncA_q;
    reg  [NSYNC-1:0] syncB_q;

    // every pin except clk, arst_n and the bus crosses two flops before any logic sees it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // reset pin copy starts released: no false release edge
            syncA_q <= {{(NSYNC-1){1'b0}}, 1'b1};
            syncB_q <= {{(NSYNC-1){1'b0}}, 1'b1};
        end else begin
            syncA_q <= rawIn;
            syncB_q <= syncA_q;
        end
    end

    wire       hwRstN   = syncB_q[0];
    wire       strapIn  = syncB_q[1];
    wire       ledStrap = syncB_q[2];
    wire       rmiiIn   = syncB_q[3];
    wire       linkIn   = syncB_q[4];
    wire       spd100In = syncB_q[5];
    wire       energyIn = syncB_q[6];
    wire       nlpIn    = syncB_q[7];
    wire       bitClkIn = syncB_q[8];
    wire       bitIn    = syncB_q[9];
    wire       txEnIn   = syncB_q[10];
    wire       txErIn   = syncB_q[11];
    wire [3:0] txDatIn  = syncB_q[15:12];
    wire       sharedIn = syncB_q[16];
    wire       hwHeld   = !hwRstN;

    ////////////////////////////////////////////////////////////////////////
    // strap capture

    reg       hwRstPrev_q;
    reg       strapDone_q;
    reg [1:0] syncFill_q;
    reg       irqMode_q;
    reg       ledActLow_q;
    reg       rmii_q;

    // the pin-function and led straps share pins with outputs, so they
    // are only sampled at power-on and at hardware reset release
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hwRstPrev_q <= 1'b1;
            strapDone_q <= 1'b0;
            syncFill_q  <= 2'h0;
            irqMode_q   <= 1'b1; // pull-up default: interrupt
            ledActLow_q <= 1'b0;
            rmii_q      <= 1'b0;
        end else begin
            hwRstPrev_q <= hwRstN;
            // power-on capture waits until the synchroniser holds pin levels
            syncFill_q  <= {syncFill_q[0], 1'b1};
            if ((syncFill_q[1] && !strapDone_q) ||
                (hwRstN && !hwRstPrev_q)) begin
                strapDone_q <= 1'b1;
                irqMode_q   <= strapIn;
                ledActLow_q <= ledStrap;
                rmii_q      <= rmiiIn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon slave and registers

    reg       softRst_q;
    reg       autoNeg_q;
    reg       fullDuplex_q;
    reg       repeater_q;
    reg       isolate_q;
    reg       pwrDown_q;
    reg       energy_detect_sleep_enable_q;
    reg       txNlpEn_q;
    reg [1:0] txNlpSel_q;
    reg       singleWake_q;
    reg [1:0] rxWinSel_q;
    reg       energyIrq_q;
    reg       energyMask_q;
    reg       energy_present_q;
    reg       wakeEvent_q;
    reg       rxCarrier_q;

    wire busReq = read || write;
    wire wrAcc  = write && !waitrequest;
    wire asleep = energy_detect_sleep_enable_q && !energy_present_q;

    // one wait state: request seen with waitrequest high, answered next
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(busReq && waitrequest);
        end
    end

    // read data is loaded while waitrequest is still high
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata <= 32'h00000000;
        end else if (read && waitrequest) begin
            readdata <= 32'h00000000;
            if (address == `REG_CONTROL) begin
                readdata[`CTRL_SOFT_RESET]  <= softRst_q;
                readdata[`CTRL_AUTONEG]     <= autoNeg_q;
                readdata[`CTRL_POWER_DOWN]  <= pwrDown_q;
                readdata[`CTRL_ISOLATE]     <= isolate_q;
                readdata[`CTRL_FULL_DUPLEX] <= fullDuplex_q;
                readdata[`CTRL_REPEATER]    <= repeater_q;
            end else if (address == `REG_STATUS) begin
                readdata[`STAT_ENERGY]     <= energy_present_q;
                readdata[`STAT_LINK]       <= linkIn;
                readdata[`STAT_SPEED100]   <= spd100In;
                readdata[`STAT_CARRIER]    <= rxCarrier_q;
                readdata[`STAT_ASLEEP]     <= asleep || pwrDown_q;
                readdata[`STAT_IRQ_MODE]   <= irqMode_q;
                readdata[`STAT_MAC_FAST]   <= macClkFast;
                readdata[`STAT_LED_ACT_LOW] <= ledActLow_q;
            end else if (address == `REG_SLEEP_CFG) begin
                readdata[`SLP_ENABLE]      <= energy_detect_sleep_enable_q;
                readdata[`SLP_TX_NLP_EN]   <= txNlpEn_q;
                readdata[`SLP_TX_SEL_LO+1:`SLP_TX_SEL_LO] <= txNlpSel_q;
                readdata[`SLP_SINGLE_WAKE] <= singleWake_q;
                readdata[`SLP_RX_SEL_LO+1:`SLP_RX_SEL_LO] <= rxWinSel_q;
            end else if (address == `REG_IRQ) begin
                readdata[`IRQ_ENERGY_STAT] <= energyIrq_q;
                readdata[`IRQ_ENERGY_MASK] <= energyMask_q;
            end
        end
    end

    // control and interrupt registers: reset by both resets; a wake in that cycle still sets the energy flag
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            softRst_q    <= 1'b0;
            autoNeg_q    <= `CTRL_AUTONEG_RST;
            fullDuplex_q <= 1'b0;
            repeater_q   <= 1'b0;
            isolate_q    <= 1'b0;
            pwrDown_q    <= 1'b0;
            energyIrq_q  <= 1'b0;
            energyMask_q <= 1'b0;
        end else if (hwHeld || softRst_q) begin
            // soft reset lasts one cycle, far inside the allowed time
            softRst_q    <= 1'b0;
            autoNeg_q    <= `CTRL_AUTONEG_RST;
            fullDuplex_q <= 1'b0;
            repeater_q   <= 1'b0;
            isolate_q    <= 1'b0;
            pwrDown_q    <= 1'b0;
            energyIrq_q  <= wakeEvent_q;
            energyMask_q <= 1'b0;
        end else begin
            if (wrAcc && address == `REG_CONTROL) begin
                softRst_q    <= writedata[`CTRL_SOFT_RESET];
                autoNeg_q    <= writedata[`CTRL_AUTONEG];
                pwrDown_q    <= writedata[`CTRL_POWER_DOWN];
                isolate_q    <= writedata[`CTRL_ISOLATE];
                fullDuplex_q <= writedata[`CTRL_FULL_DUPLEX];
                repeater_q   <= writedata[`CTRL_REPEATER];
            end
            if (wrAcc && address == `REG_IRQ) begin
                energyMask_q <= writedata[`IRQ_ENERGY_MASK];
            end
            // a wake in the same cycle as a write-one clear still sticks
            if (wakeEvent_q) begin
                energyIrq_q <= 1'b1;
            end else if (wrAcc && address == `REG_IRQ &&
                         writedata[`IRQ_ENERGY_STAT]) begin
                energyIrq_q <= 1'b0;
            end
        end
    end

    // sleep configuration is sticky: only power-on or hardware reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            energy_detect_sleep_enable_q <= 1'b0;
            txNlpEn_q    <= 1'b0;
            txNlpSel_q   <= `SLP_TX_SEL_RST;
            singleWake_q <= 1'b0;
            rxWinSel_q   <= `SLP_RX_SEL_RST;
        end else if (hwHeld) begin
            energy_detect_sleep_enable_q <= 1'b0;
            txNlpEn_q    <= 1'b0;
            txNlpSel_q   <= `SLP_TX_SEL_RST;
            singleWake_q <= 1'b0;
            rxWinSel_q   <= `SLP_RX_SEL_RST;
        end else if (wrAcc && address == `REG_SLEEP_CFG) begin
            energy_detect_sleep_enable_q <= writedata[`SLP_ENABLE];
            txNlpEn_q    <= writedata[`SLP_TX_NLP_EN];
            txNlpSel_q   <= writedata[`SLP_TX_SEL_LO+1:`SLP_TX_SEL_LO];
            singleWake_q <= writedata[`SLP_SINGLE_WAKE];
            rxWinSel_q   <= writedata[`SLP_RX_SEL_LO+1:`SLP_RX_SEL_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // energy detect sleep

    reg        nlpPrev_q;
    reg [31:0] rxWin_q;
    reg [31:0] idleCnt_q;
    reg [31:0] txNlpCnt_q;

    wire nlpRise = nlpIn && !nlpPrev_q;
    wire wakeHit = energyIn ||
        (nlpRise && (singleWake_q || rxWin_q != 32'h00000000));
    wire [31:0] rxWinLen = NLP_RX_BASE * ({30'h0, rxWinSel_q} + 32'h1);
    wire [31:0] txNlpLen = NLP_TX_BASE * ({30'h0, txNlpSel_q} + 32'h1);

    // energy flag: set by pulses or packets, dropped after quiet time;
    // registers are left untouched so waking resumes the prior state
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nlpPrev_q        <= 1'b0;
            rxWin_q          <= 32'h00000000;
            idleCnt_q        <= 32'h00000000;
            energy_present_q <= 1'b0;
            wakeEvent_q      <= 1'b0;
            txNlpCnt_q       <= 32'h00000000;
            txNlp            <= 1'b0;
        end else begin
            nlpPrev_q   <= nlpIn;
            wakeEvent_q <= wakeHit && asleep;
            if (nlpRise) begin
                rxWin_q <= rxWinLen;
            end else if (rxWin_q != 32'h00000000) begin
                rxWin_q <= rxWin_q - 32'h1;
            end
            if (wakeHit) begin
                energy_present_q <= 1'b1;
                idleCnt_q        <= 32'h00000000;
            end else if (idleCnt_q >= ENERGY_OFF - 1) begin
                energy_present_q <= 1'b0;
            end else begin
                idleCnt_q <= idleCnt_q + 32'h1;
            end
            // link pulses go out while asleep only when enabled
            txNlp <= 1'b0;
            if (asleep && txNlpEn_q) begin
                if (txNlpCnt_q >= txNlpLen - 32'h1) begin
                    txNlpCnt_q <= 32'h00000000;
                    txNlp      <= 1'b1;
                end else begin
                    txNlpCnt_q <= txNlpCnt_q + 32'h1;
                end
            end else begin
                txNlpCnt_q <= 32'h00000000;
            end
        end
    end

    // asleep is gated by the enable, so with the bit low only power-down puts the block to sleep
    wire sleeping = pwrDown_q || asleep;

    ////////////////////////////////////////////////////////////////////////
    // datapath restart and mac clock rate

    reg        pwrDownPrev_q;
    reg [15:0] slowCnt_q;

    // leaving power-down restarts the datapath as a reset does
    wire restart = hwHeld || softRst_q ||
        (pwrDownPrev_q && !pwrDown_q);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwrDownPrev_q <= 1'b0;
            slowCnt_q     <= 16'h0000;
            macClkFast    <= 1'b0;
        end else begin
            pwrDownPrev_q <= pwrDown_q;
            if (restart) begin
                slowCnt_q  <= 16'h0000;
                macClkFast <= 1'b0;
            end else if (slowCnt_q < MAC_SLOW[15:0]) begin
                slowCnt_q  <= slowCnt_q + 16'h0001;
            end else begin
                macClkFast <= autoNeg_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // carrier detect on the encoded receive stream

    reg       bitClkPrev_q;
    reg [9:0] hist_q;
    reg [1:0] csState_q;
    reg [2:0] symCnt_q;
    reg       endIdle_q;

    wire       bitTick = bitClkIn && !bitClkPrev_q;
    wire [9:0] histNext = {hist_q[8:0], bitIn};
    // newest zero plus an older zero at least two bits back
    wire twoZeros = !bitIn && (hist_q[8:1] != 8'hFF);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bitClkPrev_q <= 1'b0;
            hist_q       <= 10'h3FF;
            csState_q    <= CS_IDLE;
            symCnt_q     <= 3'h0;
            endIdle_q    <= 1'b0;
            rxCarrier_q  <= 1'b0;
        end else if (restart || sleeping) begin
            bitClkPrev_q <= bitClkIn;
            hist_q       <= 10'h3FF;
            csState_q    <= CS_IDLE;
            symCnt_q     <= 3'h0;
            endIdle_q    <= 1'b0;
            rxCarrier_q  <= 1'b0;
        end else begin
            bitClkPrev_q <= bitClkIn;
            if (bitTick) begin
                hist_q <= histNext;
                symCnt_q <= (symCnt_q == 3'h4) ? 3'h0 : symCnt_q + 3'h1;
                case (csState_q)
                    CS_IDLE: begin
                        if (twoZeros) begin
                            csState_q   <= CS_HUNT;
                            rxCarrier_q <= 1'b1;
                        end
                    end
                    CS_HUNT: begin
                        if (histNext == 10'h3FF) begin
                            csState_q   <= CS_IDLE;
                            rxCarrier_q <= 1'b0;
                        end else if (histNext ==
                                     {`CODE_J, `CODE_K}) begin
                            csState_q <= CS_FRAME;
                            symCnt_q  <= 3'h0;
                        end
                    end
                    CS_FRAME: begin
                        if (symCnt_q == 3'h4) begin
                            if (codeIs(histNext, `CODE_T) ||
                                codeIs(histNext, `CODE_IDLE)) begin
                                csState_q   <= CS_END;
                                endIdle_q   <= codeIs(histNext, `CODE_IDLE);
                                rxCarrier_q <= 1'b0;
                            end
                        end
                    end
                    CS_END: begin
                        if (symCnt_q == 3'h4) begin
                            if ((!endIdle_q && codeIs(histNext, `CODE_R)) ||
                                (endIdle_q &&
                                 codeIs(histNext, `CODE_IDLE))) begin
                                csState_q <= CS_IDLE;
                            end else begin
                                csState_q   <= CS_FRAME;
                                rxCarrier_q <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        csState_q <= CS_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mac side: transmit gating and carrier sense

    // isolate or sleep ignores transmit; the bus keeps answering
    wire txBlock = isolate_q || sleeping;
    // in transmit-error mode the shared pin carries the error input
    wire txErrSrc = irqMode_q ? txErIn : (txErIn || sharedIn);
    wire txSense = txEnIn && !txBlock && !fullDuplex_q && !repeater_q;
    wire carrier = rxCarrier_q || txSense;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txEnOut   <= 1'b0;
            txErOut   <= 1'b0;
            txDataOut <= 4'h0;
            crs       <= 1'b0;
            crsDv     <= 1'b0;
        end else begin
            txEnOut   <= txEnIn && !txBlock;
            txErOut   <= txErrSrc && !txBlock;
            txDataOut <= txBlock ? 4'h0 : txDatIn;
            crs       <= carrier && !rmii_q;
            crsDv     <= carrier && rmii_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicators and interrupt pin

    reg [31:0] blinkCnt_q;
    reg        blink_q;

    // free-running divider; its period only needs to be visible
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blinkCnt_q <= 32'h00000000;
            blink_q    <= 1'b0;
        end else if (blinkCnt_q >= BLINK_HALF - 1) begin
            blinkCnt_q <= 32'h00000000;
            blink_q    <= !blink_q;
        end else begin
            blinkCnt_q <= blinkCnt_q + 32'h1;
        end
    end

    wire linkOn  = linkIn && !sleeping && (!carrier || blink_q);
    wire speedOn = spd100In && !isolate_q && !sleeping;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link_activity_led <= 1'b0;
            speed_led         <= 1'b1;
            interrupt_out_n   <= 1'b1;
            interruptOe       <= 1'b0;
            poweredDown       <= 1'b0;
        end else begin
            link_activity_led <= linkOn ^ ledActLow_q;
            speed_led         <= speedOn ^ irqMode_q;
            interrupt_out_n   <= !(irqMode_q && energyIrq_q &&
                                   energyMask_q);
            interruptOe       <= irqMode_q;
            poweredDown       <= sleeping;
        end
    end

endmodule

/* File: phy_housekeeping_control_monitor.sv */
// port-level assertion checker for the housekeeping block
module phy_housekeeping_control_monitor (
    input logic clk,
    input logic arst_n,
    input logic read,
    input logic write,
    input logic waitrequest,
    input logic interrupt_out_n,
    input logic interruptOe,
    input logic crs,
    input logic crsDv,
    input logic txEnOut,
    input logic txErOut,
    input logic txNlp,
    input logic macClkFast,
    input logic poweredDown
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    // bus keeps answering whatever mode the datapath is in
    a_bus_answer: assert property
        ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered");
    a_answer_short: assert property
        (!waitrequest |=> waitrequest)
        else $error("answer held too long");
    // pin stays quiet unless the strap chose interrupt mode
    a_irq_mode: assert property
        (!interruptOe |-> interrupt_out_n)
        else $error("interrupt outside interrupt mode");
    a_carrier_one: assert property
        (!(crs && crsDv))
        else $error("carrier on both pins");
    a_nlp_asleep: assert property
        (txNlp |-> poweredDown)
        else $error("link pulse while awake");
    a_nlp_pulse: assert property
        (txNlp |=> !txNlp)
        else $error("link pulse longer than one cycle");
    a_mac_slow: assert property
        ($rose(arst_n) |-> !macClkFast [*8])
        else $error("mac clock fast too soon");
    // outputs are flops, so allow the gate two cycles to close
    a_asleep_quiet: assert property
        (poweredDown [*3] |-> !txEnOut && !txErOut)
        else $error("transmit while asleep");
    c_answer: cover property (read && !waitrequest);
    c_sleep: cover property (txNlp);
    c_carrier: cover property (crs);
endmodule

bind phy_housekeeping_control phy_housekeeping_control_monitor u_mon (.*);

/* File: link_partner.sv */
// line-side partner: code-bit clock and receive bits
module link_partner (
    output logic rxBitClk,
    output logic rxCodeBit
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rxBitClk = 0;
        rxCodeBit = 1;
    end
    // clock runs only inside a burst; afterwards the line shows no stale bit
    // bits start off the system clock edge so no change races a sample
    task send(input logic [15:0] b, input int n);
        #5;
        for (int i = n - 1; i >= 0; i--) begin
            rxCodeBit = b[i];
            #20 rxBitClk = 1;
            #80 rxBitClk = 0;
            #60;
        end
        rxCodeBit = ~rxCodeBit;
    endtask
endmodule

/* File: phy_housekeeping_control_tb_top.sv */
// self-checking bench for the housekeeping block
module phy_housekeeping_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, arst_n = 0, hw_reset_n = 1, irq_pin_function_strap = 1;
    logic linkLedStrap = 0, rmiiSel = 0, linkValid = 0, speed100 = 0;
    logic lineEnergy = 1, nlpReceived = 0, macTxEn = 0, macTxEr = 0;
    logic sharedTxPin = 0, read = 0, write = 0, rxBitClk, rxCodeBit;
    logic waitrequest, link_activity_led, speed_led, interrupt_out_n;
    logic interruptOe, crs, crsDv, txEnOut, txErOut, txNlp, macClkFast;
    logic poweredDown;
    logic [3:0] address = 4'h0, macTxData = 4'h0, txDataOut;
    logic [31:0] writedata = 32'h0, readdata, rdata;
    int err_count = 0, checked = 0, nlps = 0;
    // short counts keep sleep and blink within a brief run
    phy_housekeeping_control #(.BLINK_HALF(8), .ENERGY_OFF(64),
        .NLP_TX_BASE(16), .NLP_RX_BASE(16)) DUT (.*);
    link_partner lp (.*);
    always #10 clk = ~clk;
    // link pulses sent while asleep
    always @(posedge clk)
        if (txNlp === 1'b1) nlps <= nlps + 1;
    ////////////////////////////////////////////////////////////////////////
    task summarize;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, s, e);
        end
    endtask
    task w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one avalon access; waitrequest low at a rising edge ends it there
    task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_count++;
            summarize;
        end
        rdata = readdata;
        read <= 0;
        write <= 0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize;
    end
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1;
        hw_reset_n <= 0;
        linkValid <= 1;
        speed100 <= 1;
        repeat (5) @(posedge clk);
        hw_reset_n <= 1;
        w(8);
        chk(interruptOe, 1);
        chk(speed_led, 0);
        chk(link_activity_led, 1);
        acc(0, 4'h0, 0);
        chk(rdata[12], 1);
        chk(rdata[10], 0);
        lp.send(16'h000A, 4);
        w(5);
        chk(crs, 1);
        rdata = link_activity_led;
        w(8);
        chk(link_activity_led, !rdata[0]);
        lp.send(16'h03FF, 10);
        w(5);
        chk(crs, 0);
        // J K then one data symbol
        lp.send(16'h622E, 15);
        w(5);
        chk(crs, 1);
        lp.send(16'h000D, 5);
        w(5);
        chk(crs, 0);
        lp.send(16'h000E, 5);
        w(5);
        chk(crs, 1);
        lp.send(16'h01A7, 10);
        w(5);
        chk(crs, 0);
        @(posedge clk);
        macTxEn <= 1;
        macTxData <= 4'hA;
        sharedTxPin <= 1;
        acc(1, 4'h0, 32'h0000_1400);
        w(5);
        chk(txEnOut, 0);
        chk(txDataOut, 0);
        chk(speed_led, 1);
        acc(1, 4'h0, 32'h0000_1000);
        w(5);
        chk(txEnOut, 1);
        chk(txDataOut, 4'hA);
        chk(txErOut, 0);
        chk(crs, 1);
        acc(1, 4'h0, 32'h0000_1100);
        w(5);
        chk(crs, 0);
        acc(1, 4'h0, 32'h0000_1800);
        w(5);
        chk(poweredDown, 1);
        acc(1, 4'h0, 32'h0000_1000);
        w(5);
        chk(poweredDown, 0);
        chk(nlps, 0);
        acc(1, 4'h8, 32'h0000_0003);
        acc(1, 4'h0, 32'h0000_8000);
        acc(0, 4'h0, 0);
        chk(rdata[15], 0);
        acc(0, 4'h8, 0);
        chk(rdata[1:0], 2'h3);
        acc(1, 4'hC, 32'h0000_0100);
        @(posedge clk) lineEnergy <= 0;
        w(100);
        chk(poweredDown, 1);
        chk(txEnOut, 0);
        chk(nlps != 0, 1);
        chk(macClkFast, 0);
        @(posedge clk) lineEnergy <= 1;
        w(6);
        chk(poweredDown, 0);
        chk(interrupt_out_n, 0);
        acc(1, 4'hC, 32'h0000_0101);
        w(3);
        chk(interrupt_out_n, 1);
        // two link pulses inside the window wake, one does not
        @(posedge clk) lineEnergy <= 0;
        w(100);
        @(posedge clk) nlpReceived <= 1;
        @(posedge clk) nlpReceived <= 0;
        w(5);
        chk(poweredDown, 1);
        @(posedge clk) nlpReceived <= 1;
        @(posedge clk) nlpReceived <= 0;
        w(5);
        chk(poweredDown, 0);
        w(800);
        chk(macClkFast, 1);
        @(posedge clk);
        irq_pin_function_strap <= 0;
        rmiiSel <= 1;
        hw_reset_n <= 0;
        repeat (5) @(posedge clk);
        hw_reset_n <= 1;
        w(8);
        chk(interruptOe, 0);
        chk(speed_led, 1);
        chk(txErOut, 1);
        chk(crsDv, 1);
        chk(crs, 0);
        summarize;
    end
endmodule
